// [mrft_monitor_dev.sv]
// monitor end: value store, window compare and fan tachometer counter
`timescale 1ns/1ps
module mrft_monitor_dev
  import mrft_pkg::*;
#(
  parameter int unsigned OSC_DIV_CYC = OSC_DIV_DEF
) (
  input  wire logic       clk,
  input  wire logic       srst,
  mrft_bus_if.dev         bus,
  input  wire logic       tach_input_one,
  input  wire logic       tach_input_two,
  output logic            conv_start,
  output logic            conv_abort,
  output logic [2:0]      conv_sel,
  input  wire logic       conv_done,
  input  wire logic [7:0] conv_code,
  output logic            int_n,
  output logic            running
);

  localparam logic [13:0] OSC_LAST = 14'(OSC_DIV_CYC - 1);

  typedef struct packed {
    mrft_state_t      st;
    logic [2:0]       ch;
    logic [7:0][7:0]  vals;
    logic [7:0][7:0]  hi;
    logic [7:0][7:0]  lo;
    logic [7:0]       status;
    logic [7:0]       mask;
    logic             start;
    logic             int_clr;
    logic [1:0]       mode;
    logic [1:0][1:0]  fdiv;
    logic [13:0]      osc_cnt;
    logic [3:0]       pre_cnt;
    logic [7:0]       fcnt;
    logic [1:0]       edges;
    logic [1:0]       sync1;
    logic [1:0]       sync2;
    logic [1:0]       tach_prev;
    logic             ack;
    logic [7:0]       rdata;
    logic             conv_start;
    logic             conv_abort;
    logic             int_n;
  } mrft_dev_reg_t;

  mrft_dev_reg_t s_r;
  mrft_dev_reg_t s_nxt;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic in_range(input logic [4:0] a, input logic [4:0] base);
    return (a >= base) && (a < 5'(base + 5'h8));
  endfunction

  function automatic logic ch_on(input logic [2:0] c, input logic [1:0] m);
    logic on;
    on = 1'b1;
    if (c == CH_AUX1) on = m[0];
    else if (c == CH_AUX2) on = m[1];
    else if (c == CH_TACH_INPUT_ONE) on = !m[0];
    else if (c == CH_TACH_INPUT_TWO) on = !m[1];
    return on;
  endfunction

  // skips slots whose pin is in the other mode; fans come last
  function automatic logic [2:0] next_ch(input logic [2:0] c, input logic [1:0] m);
    logic [2:0] k;
    k = c;
    for (int i = 0; i < 4; i++) begin
      k = k + 3'h1;
      if (ch_on(k, m)) return k;
    end
    return CH_FIRST;
  endfunction

  function automatic logic [3:0] div_last(input logic [1:0] code);
    return 4'((4'h1 << code) - 4'h1);
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic       run;
  logic       tick;
  logic       ptick;
  logic       rd_val;
  logic       done;
  logic       rise;
  logic       fi;
  logic [7:0] res;
  logic [7:0] set;
  logic [7:0] clr;

  always_comb begin
    s_nxt  = s_r;
    tick   = 1'b0;
    ptick  = 1'b0;
    rd_val = 1'b0;
    done   = 1'b0;
    res    = 8'h00;
    set    = 8'h00;
    clr    = 8'h00;
    fi     = s_r.ch[0];
    run    = s_r.start && !s_r.int_clr;
    s_nxt.ack        = 1'b0;
    s_nxt.conv_start = 1'b0;
    s_nxt.conv_abort = 1'b0;

    // tach pins are asynchronous: two flops before use
    s_nxt.sync1     = {tach_input_two, tach_input_one};
    s_nxt.sync2     = s_r.sync1;
    s_nxt.tach_prev = s_r.sync2;
    rise = s_r.sync2[fi] && !s_r.tach_prev[fi];

    if (s_r.osc_cnt == OSC_LAST) begin
      s_nxt.osc_cnt = 14'h0000;
      tick          = 1'b1;
    end else begin
      s_nxt.osc_cnt = s_r.osc_cnt + 14'h0001;
    end

    // --------------------------------------------------------------
    // register access, one answer per request
    // --------------------------------------------------------------
    if (bus.req && !s_r.ack) begin
      s_nxt.ack = 1'b1;
      if (bus.we) begin
        if (in_range(bus.addr, ADDR_HI_BASE)) begin
          s_nxt.hi[bus.addr[2:0]] = bus.wdata;
        end else if (in_range(bus.addr, ADDR_LO_BASE)) begin
          s_nxt.lo[bus.addr[2:0]] = bus.wdata;
        end else if (bus.addr == ADDR_CFG) begin
          s_nxt.start   = bus.wdata[CFG_START_BIT];
          s_nxt.int_clr = bus.wdata[CFG_ICLR_BIT];
        end else if (bus.addr == ADDR_MODE) begin
          s_nxt.mode = bus.wdata[1:0]; // [RULE_14]
        end else if (bus.addr == ADDR_FDIV) begin
          s_nxt.fdiv = bus.wdata[3:0]; // [RULE_11]
        end else if (bus.addr == ADDR_STAT) begin
          clr = bus.wdata;
        end else if (bus.addr == ADDR_MASK) begin
          s_nxt.mask = bus.wdata;
        end
      end else begin
        if (in_range(bus.addr, ADDR_VAL_BASE)) begin
          s_nxt.rdata = s_r.vals[bus.addr[2:0]]; // [RULE_01]
          rd_val      = 1'b1;
        end else if (in_range(bus.addr, ADDR_HI_BASE)) begin
          s_nxt.rdata = s_r.hi[bus.addr[2:0]];
        end else if (in_range(bus.addr, ADDR_LO_BASE)) begin
          s_nxt.rdata = s_r.lo[bus.addr[2:0]];
        end else if (bus.addr == ADDR_CFG) begin
          s_nxt.rdata = 8'h00;
          s_nxt.rdata[CFG_START_BIT] = s_r.start;
          s_nxt.rdata[CFG_ICLR_BIT]  = s_r.int_clr;
        end else if (bus.addr == ADDR_MODE) begin
          s_nxt.rdata = {6'h00, s_r.mode};
        end else if (bus.addr == ADDR_FDIV) begin
          s_nxt.rdata = {4'h0, s_r.fdiv};
        end else if (bus.addr == ADDR_STAT) begin
          s_nxt.rdata = s_r.status;
        end else if (bus.addr == ADDR_MASK) begin
          s_nxt.rdata = s_r.mask;
        end else begin
          s_nxt.rdata = 8'h00;
        end
      end
    end

    // --------------------------------------------------------------
    // round-robin sequencer
    // --------------------------------------------------------------
    case (s_r.st)
      ST_IDLE: begin
        if (run) begin
          s_nxt.ch = ch_on(CH_FIRST, s_r.mode) ? CH_FIRST : next_ch(CH_FIRST, s_r.mode);
          s_nxt.st = ST_ISSUE; // [RULE_15]
        end
      end
      ST_ISSUE: begin
        if (s_r.ch == CH_TACH_INPUT_ONE || s_r.ch == CH_TACH_INPUT_TWO) begin
          s_nxt.st      = ST_FAN;
          s_nxt.edges   = 2'h0;
          s_nxt.fcnt    = 8'h00;
          s_nxt.pre_cnt = 4'h0;
        end else begin
          s_nxt.conv_start = 1'b1;
          s_nxt.st         = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (conv_done) begin
          res  = conv_code; // [RULE_06]
          done = 1'b1;
        end
      end
      ST_FAN: begin
        if (tick) begin
          if (s_r.pre_cnt == div_last(s_r.fdiv[fi])) begin
            s_nxt.pre_cnt = 4'h0;
            ptick         = 1'b1; // [RULE_10]
          end else begin
            s_nxt.pre_cnt = s_r.pre_cnt + 4'h1;
          end
        end
        if (rise && s_r.edges == 2'h0) begin
          s_nxt.edges   = 2'h1;
          s_nxt.fcnt    = 8'h00;
          s_nxt.pre_cnt = 4'h0;
        end else if ((rise && s_r.edges == EDGE_LAST) || s_r.fcnt == FCNT_MAX) begin
          res  = s_r.fcnt; // [RULE_09] [RULE_12]
          done = 1'b1;
        end else begin
          if (rise) s_nxt.edges = s_r.edges + 2'h1;
          // stopped fan ends here at full scale
          if (ptick) s_nxt.fcnt = s_r.fcnt + 8'h01; // [RULE_16]
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase

    if (done) begin
      s_nxt.vals[s_r.ch] = res; // [RULE_01]
      if (res > s_r.hi[s_r.ch] || res <= s_r.lo[s_r.ch]) begin
        set[s_r.ch] = 1'b1; // [RULE_07]
      end
      s_nxt.ch = next_ch(s_r.ch, s_r.mode); // [RULE_15]
      s_nxt.st = ST_ISSUE;
    end

    if (!run && s_r.st != ST_IDLE) begin
      s_nxt.conv_abort = (s_r.st == ST_WAIT);
      s_nxt.st         = ST_IDLE;
    end else if (rd_val && (s_r.st == ST_WAIT || s_r.st == ST_FAN)) begin
      // a value read throws away the conversion in flight
      s_nxt.conv_abort = (s_r.st == ST_WAIT); // [RULE_02]
      s_nxt.st         = ST_ISSUE; // [RULE_02]
    end

    // set wins over a clear in the same cycle
    s_nxt.status = (s_r.status & ~clr) | set;
    s_nxt.int_n  = s_r.int_clr || !(|(s_nxt.status & ~s_r.mask)); // [RULE_08]

    if (srst) begin
      s_nxt         = '0;
      s_nxt.hi      = {VAL_NUM{LIM_HI_RST}};
      s_nxt.int_clr = ICLR_RST;
      s_nxt.fdiv    = {FDIV_RST, FDIV_RST}; // [RULE_10]
      s_nxt.int_n   = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    s_r <= s_nxt;
  end

  assign bus.ack    = s_r.ack;
  assign bus.rdata  = s_r.rdata;
  assign conv_start = s_r.conv_start;
  assign conv_abort = s_r.conv_abort;
  assign conv_sel   = s_r.ch;
  assign int_n      = s_r.int_n;
  assign running    = (s_r.st != ST_IDLE);

endmodule

// [mrft_pkg.sv]
// shared constants and types for the monitor readout and fan tachometer block
// Operation
// RULE_01: store keeps last completed result per channel
// RULE_02: reading a value restarts the current conversion
// RULE_03: host reads one value at most every 56 ms
// RULE_04: host waits 0.6 s between full read groups
// RULE_05: host sets limits, then masks, then starts
// RULE_06: results are unsigned 8-bit codes, 255 full scale
// RULE_07: flag when value above high or at/below low
// RULE_08: flag drives interrupt low only when unmasked
// RULE_09: fan counts scaled 22.5 kHz over tach period; the code counts from the first tach rise to the third, two tach periods
// RULE_10: divisor 1, 2, 4 or 8, default 2
// RULE_11: each fan has its own divisor
// RULE_12: count is 1.35e6 over rpm times divisor
// RULE_13: one-pulse fans use double the divisor
// RULE_14: mode bit picks tach or auxiliary analog input
// RULE_15: start high, clear low runs round-robin, fans last
// RULE_16: fan counter saturates at 255, never wraps
package mrft_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_VAL_BASE = 5'h00;
  localparam logic [4:0] ADDR_HI_BASE  = 5'h08;
  localparam logic [4:0] ADDR_LO_BASE  = 5'h10;
  localparam logic [4:0] ADDR_CFG      = 5'h18;
  localparam logic [4:0] ADDR_MODE     = 5'h19;
  localparam logic [4:0] ADDR_FDIV     = 5'h1A;
  localparam logic [4:0] ADDR_STAT     = 5'h1B;
  localparam logic [4:0] ADDR_MASK     = 5'h1C;
  localparam logic [4:0] ADDR_END      = 5'h1D;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CFG_START_BIT = 0;
  localparam int unsigned CFG_ICLR_BIT  = 3;
  localparam logic        ICLR_RST      = 1'b1;
  localparam logic [1:0]  FDIV_RST      = 2'h1;
  localparam logic [7:0]  LIM_HI_RST    = 8'hFF;
  localparam logic [7:0]  FCNT_MAX      = 8'hFF;
  localparam logic [1:0]  EDGE_LAST     = 2'h2;
  localparam int unsigned VAL_NUM       = 8;

  // ----------------------------------------------------------------
  // channel slots
  // ----------------------------------------------------------------
  localparam logic [2:0] CH_FIRST = 3'h0;
  localparam logic [2:0] CH_AUX1  = 3'h4;
  localparam logic [2:0] CH_AUX2  = 3'h5;
  localparam logic [2:0] CH_TACH_INPUT_ONE  = 3'h6;
  localparam logic [2:0] CH_TACH_INPUT_TWO  = 3'h7;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam real         CLK_HZ        = 200.0e6;
  localparam real         OSC_HZ        = 22.5e3;
  localparam real         READ_GAP_MS   = 56.0;
  localparam real         GROUP_GAP_S   = 0.6;
  localparam int unsigned OSC_DIV_DEF   = $rtoi(CLK_HZ / OSC_HZ);
  localparam int unsigned READ_GAP_DEF  = $rtoi($ceil(READ_GAP_MS * CLK_HZ / 1000.0));
  localparam int unsigned GROUP_GAP_DEF = $rtoi($ceil(GROUP_GAP_S * CLK_HZ));

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ISSUE = 2'b01,
    ST_WAIT  = 2'b10,
    ST_FAN   = 2'b11
  } mrft_state_t;

endpackage

// [mrft_bus_if.sv]
// register access link between host controller and monitor
`timescale 1ns/1ps
interface mrft_bus_if;
  logic       req;
  logic       we;
  logic [4:0] addr;
  logic [7:0] wdata;
  logic       ack;
  logic [7:0] rdata;

  modport dev  (input req, input we, input addr, input wdata, output ack, output rdata);
  modport host (output req, output we, output addr, output wdata, input ack, input rdata);
endinterface

// [mrft_host_ctl.sv]
// host end: paced register access to the monitor
`timescale 1ns/1ps
module mrft_host_ctl
  import mrft_pkg::*;
#(
  parameter int unsigned READ_GAP_CYC  = READ_GAP_DEF,
  parameter int unsigned GROUP_GAP_CYC = GROUP_GAP_DEF
) (
  input  wire logic       clk,
  input  wire logic       srst,
  mrft_bus_if.host        bus,
  input  wire logic       cmd_valid,
  input  wire logic       cmd_we,
  input  wire logic [4:0] cmd_addr,
  input  wire logic [7:0] cmd_wdata,
  output logic            cmd_ready,
  output logic            rsp_valid,
  output logic [7:0]      rsp_data
);

  typedef struct packed {
    logic        busy;
    logic        we;
    logic [4:0]  addr;
    logic [7:0]  wdata;
    logic        rsp_valid;
    logic [7:0]  rsp_data;
    logic [31:0] gap;
    logic [31:0] grp;
    logic [3:0]  nread;
    logic        lim_ok;
    logic        mask_ok;
  } mrft_host_reg_t;

  mrft_host_reg_t s_r;
  mrft_host_reg_t s_nxt;

  logic is_val;
  logic is_lim;
  logic blk;
  logic take;

  always_comb begin
    is_val = (cmd_addr < ADDR_HI_BASE);
    is_lim = (cmd_addr >= ADDR_HI_BASE) && (cmd_addr < ADDR_CFG);
    blk    = 1'b0;
    // pacing is conservative: one gap shared by all value reads
    if (!cmd_we && is_val && (s_r.gap != 32'h0 || s_r.grp != 32'h0)) blk = 1'b1; // [RULE_03] [RULE_04]
    if (cmd_we && cmd_addr == ADDR_MASK && !s_r.lim_ok) blk = 1'b1; // [RULE_05]
    if (cmd_we && cmd_addr == ADDR_CFG && cmd_wdata[CFG_START_BIT]
        && !(s_r.lim_ok && s_r.mask_ok)) blk = 1'b1; // [RULE_05]
    cmd_ready = !s_r.busy && !blk;
    take      = cmd_valid && cmd_ready;

    s_nxt           = s_r;
    s_nxt.rsp_valid = 1'b0;
    if (s_r.gap != 32'h0) s_nxt.gap = s_r.gap - 32'h1;
    if (s_r.grp != 32'h0) s_nxt.grp = s_r.grp - 32'h1;

    if (take) begin
      s_nxt.busy  = 1'b1;
      s_nxt.we    = cmd_we;
      s_nxt.addr  = cmd_addr;
      s_nxt.wdata = cmd_wdata;
      if (cmd_we && is_lim) s_nxt.lim_ok = 1'b1;
      if (cmd_we && cmd_addr == ADDR_MASK) s_nxt.mask_ok = 1'b1;
      if (!cmd_we && is_val) begin
        s_nxt.gap = READ_GAP_CYC; // [RULE_03]
        if (s_r.nread == 4'(VAL_NUM - 1)) begin
          s_nxt.nread = 4'h0;
          s_nxt.grp   = GROUP_GAP_CYC; // [RULE_04]
        end else begin
          s_nxt.nread = s_r.nread + 4'h1;
        end
      end
    end else if (s_r.busy && bus.ack) begin
      s_nxt.busy      = 1'b0;
      s_nxt.rsp_valid = 1'b1;
      s_nxt.rsp_data  = bus.rdata;
    end

    if (srst) begin
      s_nxt = '0;
    end
  end

  always_ff @(posedge clk) begin
    s_r <= s_nxt;
  end

  assign bus.req   = s_r.busy;
  assign bus.we    = s_r.we;
  assign bus.addr  = s_r.addr;
  assign bus.wdata = s_r.wdata;
  assign rsp_valid = s_r.rsp_valid;
  assign rsp_data  = s_r.rsp_data;

endmodule

// [mrft_bus_properties.sv]
// protocol and pacing assertions for the monitor register link
`timescale 1ns/1ps
module mrft_bus_properties
  import mrft_pkg::*;
#(
  parameter int unsigned READ_GAP_CYC = READ_GAP_DEF
) (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       req,
  input wire logic       we,
  input wire logic [4:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       ack,
  input wire logic [7:0] rdata
);
  // ----------
  // helper: cycles since the last value read request
  // ----------
  logic        req_q;
  logic        seen_rd;
  logic [31:0] gap_cnt;
  wire         vrd = req && !req_q && !we && (addr < ADDR_HI_BASE);

  always_ff @(posedge clk) begin
    if (srst) begin
      req_q   <= 1'b0;
      seen_rd <= 1'b0;
      gap_cnt <= 32'h0;
    end else begin
      req_q   <= req;
      seen_rd <= seen_rd | vrd;
      gap_cnt <= vrd ? 32'h0 : gap_cnt + 32'h1;
    end
  end

  // ----------
  // properties
  // ----------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_ack_after_take: assert property ($rose(req) |=> ack)
    else $error("no answer one cycle after request");
  a_ack_one_pulse: assert property (ack |=> !ack)
    else $error("answer longer than one cycle");
  a_ack_needs_req: assert property (!req |=> !ack)
    else $error("answer without request");
  a_req_held: assert property (
    req && !ack |=> req && $stable(addr) && $stable(we) && $stable(wdata))
    else $error("request changed before answer");
  a_req_release: assert property (ack |=> !req)
    else $error("request kept after answer");
  a_rdata_moves: assert property ($changed(rdata) |-> ack)
    else $error("read data changed outside answer");
  a_unmapped_zero: assert property (req && !ack && !we && addr >= 5'h1D |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_value_gap: assert property (vrd |-> !seen_rd || gap_cnt >= READ_GAP_CYC - 1)
    else $error("value reads too close");

  c_write: cover property ($rose(req) && we);
  c_value_read: cover property (vrd);
  c_unmapped: cover property (req && !we && addr >= 5'h1D);
endmodule

// [monitor_readout_fan_tach_test.sv]
// self-checking bench: host and monitor ends joined over the register link
`timescale 1ns/1ps
module monitor_readout_fan_tach_test
  import mrft_pkg::*;
;
  localparam int unsigned RD_GAP  = 20;
  localparam int unsigned GRP_GAP = 60;
  localparam int unsigned OSC_CYC = 4;
  localparam logic [7:0]  FAN_EXP = 8'(400 / OSC_CYC);

  logic       clk;
  logic       srst;
  logic       cmd_valid;
  logic       cmd_we;
  logic [4:0] cmd_addr;
  logic [7:0] cmd_wdata;
  logic       cmd_ready;
  logic       rsp_valid;
  logic [7:0] rsp_data;
  logic       tach_one = 1'b0;
  logic       conv_start;
  logic       conv_abort;
  logic [2:0] conv_sel;
  logic       conv_done = 1'b0;
  logic [7:0] conv_code;
  logic       int_n;
  logic       running;
  logic [7:0] cv_cnt = 8'h00;
  logic [7:0] t_cnt = 8'h00;
  logic [2:0] prev_sel;
  logic [2:0] seq[$];
  logic [7:0] codes[8] = '{8'h10, 8'hFF, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45};
  logic [2:0] loop_fan[6] = '{3'h1, 3'h2, 3'h3, 3'h6, 3'h7, 3'h0};
  int         err_count;
  int         n_compared;
  int         n_abort;
  int         cyc;

  // ----------
  // design under test
  // ----------
  mrft_bus_if mrft_bus_if_i ();
  mrft_monitor_dev #(.OSC_DIV_CYC(OSC_CYC)) mrft_monitor_dev_i (
    .clk(clk), .srst(srst), .bus(mrft_bus_if_i), .tach_input_one(tach_one),
    .tach_input_two(1'b0), .conv_start(conv_start), .conv_abort(conv_abort),
    .conv_sel(conv_sel), .conv_done(conv_done), .conv_code(conv_code),
    .int_n(int_n), .running(running));
  mrft_host_ctl #(.READ_GAP_CYC(RD_GAP), .GROUP_GAP_CYC(GRP_GAP)) mrft_host_ctl_i (
    .clk(clk), .srst(srst), .bus(mrft_bus_if_i), .cmd_valid(cmd_valid), .cmd_we(cmd_we),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  mrft_bus_properties #(.READ_GAP_CYC(RD_GAP)) mrft_bus_properties_i (
    .clk(clk), .srst(srst), .req(mrft_bus_if_i.req), .we(mrft_bus_if_i.we),
    .addr(mrft_bus_if_i.addr), .wdata(mrft_bus_if_i.wdata), .ack(mrft_bus_if_i.ack),
    .rdata(mrft_bus_if_i.rdata));

  // ----------
  // stand-ins: slow converter so reads land mid-conversion, fan at 200 clock period
  // ----------
  assign conv_code = conv_done ? codes[conv_sel] : ~codes[conv_sel];

  always @(posedge clk) begin
    conv_done <= 1'b0;
    prev_sel <= conv_sel;
    cyc <= cyc + 1;
    t_cnt <= (t_cnt == 8'h63) ? 8'h00 : t_cnt + 8'h01;
    if (t_cnt == 8'h63) tach_one <= ~tach_one;
    if (conv_abort === 1'b1) n_abort <= n_abort + 1;
    if (!srst && conv_sel != prev_sel) seq.push_back(conv_sel);
    if (srst || conv_abort) cv_cnt <= 8'h00;
    else if (conv_start) cv_cnt <= 8'h28;
    else if (cv_cnt != 8'h00) cv_cnt <= cv_cnt - 8'h01;
    if (cv_cnt == 8'h01 && !conv_abort) conv_done <= 1'b1;
    if (cyc == 60000) begin
      err_count++;
      stop_test();
    end
  end

  // ----------
  // tasks
  // ----------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cmd(input logic w, input logic [4:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_we <= w;
    cmd_addr <= a;
    cmd_wdata <= d;
    do @(negedge clk); while (cmd_ready !== 1'b1);
    @(posedge clk);
    cmd_valid <= 1'b0;
    do @(negedge clk); while (rsp_valid !== 1'b1);
    q = rsp_data;
  endtask

  // refusal shows only on cmd_ready, so probe with valid low
  task automatic probe(input logic w, input logic [4:0] a, input logic [7:0] d, input logic e);
    @(posedge clk);
    cmd_we <= w;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(negedge clk);
    chk("cmd_ready", {7'h0, cmd_ready}, {7'h0, e});
  endtask

  task automatic chk_loop(input logic [2:0] e[6]);
    while (seq.size() < 6) @(posedge clk);
    foreach (e[i]) chk("slot order", {5'h0, seq[i]}, {5'h0, e[i]});
  endtask

  task automatic t_reset;
    logic [4:0] a[5] = '{ADDR_HI_BASE, ADDR_LO_BASE, ADDR_FDIV, ADDR_STAT, ADDR_END};
    logic [7:0] e[5] = '{8'hFF, 8'h00, 8'h05, 8'h00, 8'h00};
    logic [7:0] q;
    foreach (a[i]) begin
      cmd(1'b0, a[i], 8'h00, q);
      chk("reset value", q, e[i]);
    end
    chk("int_n", {7'h0, int_n}, 8'h01);
  endtask

  task automatic t_setup;
    logic [7:0] q;
    probe(1'b1, ADDR_MASK, 8'hFE, 1'b0);
    probe(1'b1, ADDR_CFG, 8'h01, 1'b0);
    cmd(1'b1, ADDR_LO_BASE, 8'h10, q);
    cmd(1'b1, ADDR_HI_BASE + 5'h02, 8'h3F, q);
    probe(1'b1, ADDR_CFG, 8'h01, 1'b0);
    cmd(1'b1, ADDR_MASK, 8'hFE, q);
    // stand-in fan gives two pulses a turn, so its divisor is not doubled
    cmd(1'b1, ADDR_FDIV, 8'h0C, q);
    cmd(1'b0, ADDR_FDIV, 8'h00, q);
    chk("divisors", q, 8'h0C);
    cmd(1'b1, ADDR_CFG, 8'h01, q);
    chk("running", {7'h0, running}, 8'h01);
  endtask

  task automatic t_reads;
    logic [7:0] e[8] = '{8'h10, 8'hFF, 8'h40, 8'h41, 8'h00, 8'h00, FAN_EXP, 8'hFF};
    logic [7:0] q;
    int         na;
    na = n_abort;
    foreach (e[i]) begin
      cmd(1'b0, ADDR_VAL_BASE + 5'(i), 8'h00, q);
      if (i == 0) chk("abort", {7'h0, n_abort > na}, 8'h01);
      if (i == 0) probe(1'b0, ADDR_VAL_BASE, 8'h00, 1'b0);
      // oscillator phase against the tach edge costs one count either way
      if (i == 6 && q >= FAN_EXP - 8'h01 && q <= FAN_EXP + 8'h01) q = FAN_EXP;
      chk("value", q, e[i]);
    end
    repeat (RD_GAP + 5) @(posedge clk);
    probe(1'b0, ADDR_VAL_BASE, 8'h00, 1'b0);
    repeat (GRP_GAP) @(posedge clk);
    probe(1'b0, ADDR_VAL_BASE, 8'h00, 1'b1);
  endtask

  task automatic t_irq;
    logic [7:0] q;
    chk("int_n", {7'h0, int_n}, 8'h00);
    cmd(1'b0, ADDR_STAT, 8'h00, q);
    chk("status", q, 8'h05);
    cmd(1'b1, ADDR_MASK, 8'hFF, q);
    repeat (2) @(negedge clk);
    chk("int_n", {7'h0, int_n}, 8'h01);
  endtask

  task automatic t_mode;
    logic [2:0] e[6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h7, 3'h0};
    logic [7:0] q;
    cmd(1'b1, ADDR_MODE, 8'h01, q);
    seq.delete();
    while (seq.size() == 0 || seq[$] !== 3'h0) @(posedge clk);
    seq.delete();
    chk_loop(e);
    cmd(1'b0, ADDR_VAL_BASE + 5'h04, 8'h00, q);
    chk("aux value", q, codes[4]);
  endtask

  // setting the clear bit stops the loop and silences the interrupt output; flags written clear then read back as zero
  task automatic t_stop;
    logic [7:0] q;
    cmd(1'b1, ADDR_MASK, 8'hFE, q);
    repeat (2) @(negedge clk);
    chk("int_n", {7'h0, int_n}, 8'h00);
    cmd(1'b1, ADDR_CFG, 8'h08, q);
    repeat (2) @(negedge clk);
    chk("running", {7'h0, running}, 8'h00);
    chk("int_n", {7'h0, int_n}, 8'h01);
    cmd(1'b1, ADDR_STAT, 8'hFF, q);
    cmd(1'b0, ADDR_STAT, 8'h00, q);
    chk("status", q, 8'h00);
  endtask

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ----------
  // sequence
  // ----------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    srst = 1'b1;
    cmd_valid = 1'b0;
    cmd_we = 1'b0;
    cmd_addr = 5'h00;
    cmd_wdata = 8'h00;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_setup();
    chk_loop(loop_fan);
    t_reads();
    t_irq();
    t_mode();
    t_stop();
    stop_test();
  end
endmodule
